//--- rtl/hbap_pkg.sv
// Purpose: shared constants and types of the host bus autodetect port
// Assumes: sys_clk at 250 MHz
// Notes:   host pins arrive asynchronous and are synchronised in the core
package hbap_pkg;
   // *****************************
   // timing, fifo and bus constants
   // *****************************
   localparam int          CLK_MHZ        = 250;
   localparam int          STARTUP_US     = 1000;
   localparam int          STARTUP_CYC    = STARTUP_US * CLK_MHZ - 1;
   localparam int          CNT_W          = 18;
   localparam logic [7:0]  FIFO_DEPTH     = 8'h40;
   localparam logic [2:0]  FIFO_ADDR      = 3'h2;
   localparam logic [2:0]  LEVEL_ADDR     = 3'h3;
   localparam logic [7:0]  DATA_RESET     = 8'h00;

   // *****************************
   // types
   // *****************************
   typedef enum logic [1:0] {
      HB_SEP_RDWR = 2'b00,
      HB_SEP_DS   = 2'b01,
      HB_MUX_RDWR = 2'b11,
      HB_MUX_DS   = 2'b10
   } hbap_style_t;

   typedef enum logic [1:0] {
      ST_HELD  = 2'b00,
      ST_START = 2'b01,
      ST_DET   = 2'b11,
      ST_RUN   = 2'b10
   } hbap_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic [2:0] addr;
      logic       write_strobe_n;
      logic       read_strobe_n;
      logic       chip_select_n;
      logic       ale;
   } hbap_pins_t;

   typedef struct packed {
      logic [7:0] data_o;
      logic [7:0] data_oe_n;
      logic       miso_o;
      logic       miso_oe_n;
   } hbap_drive_t;
endpackage : hbap_pkg

//--- rtl/hbap_sync.sv
// Purpose: two-flop synchroniser for host pins
// Assumes: inputs asynchronous to sys_clk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module hbap_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk)
   begin
      meta_q <= din;
      dout   <= meta_q;
   end
endmodule : hbap_sync

//--- rtl/hbap_core.sv
// Purpose: host front end, parallel bus autodetect and SPI slave to the FIFO
// Assumes: one clock; hard_reset_pin asynchronous, synchronised here
// Notes:   FIFO reached at a fixed address, fill level beside it
`timescale 1ns/1ps
module hbap_core
   import hbap_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_CYC
) (
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic                  hard_reset_pin,
   input  wire hbap_pkg::hbap_pins_t  pins_i,
   input  wire logic                  irq_req,
   output hbap_pkg::hbap_drive_t      drive_o,
   output logic                       irq,
   output logic                       ready,
   output hbap_pkg::hbap_style_t      style,
   output logic                       spi_mode
);
   import hbap_pkg::*;

   // *****************************
   // input synchronisers
   // *****************************
   hbap_pins_t pins_s;
   logic       rst_s;

   hbap_sync #(.W($bits(hbap_pins_t) + 1)) u_sync (
      .sys_clk (sys_clk),
      .din     ({pins_i, hard_reset_pin}),
      .dout    ({pins_s, rst_s})
   );

   wire hold = reset | rst_s;

   // *****************************
   // start-up sequencer
   // *****************************
   hbap_state_t      state_q;
   logic [CNT_W-1:0] cnt_q;
   hbap_style_t      style_q;
   logic             mux_q;
   logic             spi_q;
   logic             prev_cs_n_q;
   logic             prev_rd_q;
   logic             prev_wr_q;
   logic             prev_ale_q;
   logic             prev_sck_q;

   wire done_cnt = (cnt_q == CNT_W'(STARTUP_CYCLES));
   wire cs_fall  = prev_cs_n_q & ~pins_s.chip_select_n;
   wire ale_fall = prev_ale_q & ~pins_s.ale;

   always_ff @(posedge sys_clk)
   begin
      if (hold)
      begin
         state_q <= ST_HELD;
         cnt_q   <= '0;
         style_q <= HB_SEP_RDWR;
         mux_q   <= 1'b0;
         spi_q   <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_HELD:  state_q <= ST_START;
            ST_START:
            begin
               cnt_q <= cnt_q + CNT_W'(1);
               if (done_cnt)
                  state_q <= ST_DET;
            end
            ST_DET:
            begin
               if (ale_fall & pins_s.chip_select_n)
                  mux_q <= 1'b1;
               if (!pins_s.ale && pins_s.chip_select_n && !mux_q)
               begin
                  spi_q   <= 1'b1;
                  mux_q   <= 1'b0;
                  state_q <= ST_RUN;
               end
               else if (cs_fall)
               begin
                  // both strobes low means rnw plus ds style
                  style_q <= hbap_style_t'({mux_q | ~pins_s.ale,
                             ~pins_s.write_strobe_n & ~pins_s.read_strobe_n ^ (mux_q | ~pins_s.ale)});
                  mux_q   <= mux_q | ~pins_s.ale;
                  state_q <= ST_RUN;
               end
            end
            default:  state_q <= ST_RUN;
         endcase
      end
   end

   wire run    = (state_q == ST_RUN);
   wire ds_sty = (style_q == HB_SEP_DS) | (style_q == HB_MUX_DS);
   // start-up over, detection may still be pending
   wire started = run | (state_q == ST_DET);

   // fifo address decode
   function automatic logic is_fifo(input logic [2:0] a);
      return a == FIFO_ADDR;
   endfunction : is_fifo

   // *****************************
   // parallel decode
   // *****************************
   logic [2:0] addr_q;
   wire  sel      = run & ~spi_q & ~pins_s.chip_select_n;
   wire  rd_act   = ds_sty ? (~pins_s.read_strobe_n & pins_s.write_strobe_n)
                           : ~pins_s.read_strobe_n;
   wire  wr_act   = ds_sty ? (~pins_s.read_strobe_n & ~pins_s.write_strobe_n)
                           : ~pins_s.write_strobe_n;
   wire  strobe   = rd_act | wr_act;
   logic prev_strobe_q;
   wire  wr_end   = sel & prev_strobe_q & ~strobe & prev_wr_q;
   wire  rd_end   = sel & prev_strobe_q & ~strobe & prev_rd_q;
   wire [2:0] acc_addr = mux_q ? addr_q : pins_s.addr;

   // *****************************
   // fifo, 64 bytes, shared by both ports
   // *****************************
   logic [7:0] mem [0:63];
   logic [5:0] wp_q;
   logic [5:0] rp_q;
   logic [6:0] lvl_q;
   logic [7:0] rd_data_q;

   // *****************************
   // spi slave
   // *****************************
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   wire  spi_sel  = run & spi_q & ~pins_s.ale;
   wire  sck_rise = spi_sel & ~prev_sck_q & pins_s.addr[2];
   wire  sck_fall = spi_sel & prev_sck_q & ~pins_s.addr[2];
   wire  spi_byte = sck_rise & (bit_q == 3'h7);

   wire  push     = ((wr_end & is_fifo(acc_addr)) | spi_byte) & (lvl_q != 7'(FIFO_DEPTH));
   wire  pop      = ((rd_end & is_fifo(acc_addr)) | spi_byte) & (lvl_q != 7'h00);
   wire  [7:0] push_data = spi_byte ? {sh_q[6:0], pins_s.addr[0]} : pins_s.data;

   always_ff @(posedge sys_clk)
   begin
      prev_cs_n_q   <= pins_s.chip_select_n;
      prev_ale_q    <= pins_s.ale;
      prev_sck_q    <= pins_s.addr[2];
      prev_strobe_q <= strobe;
      prev_rd_q     <= rd_act;
      prev_wr_q     <= wr_act;
      if (run & mux_q & ale_fall)
         addr_q <= pins_s.data[2:0];
      if (push)
         mem[wp_q] <= push_data;
   end

   always_ff @(posedge sys_clk)
   begin
      if (hold)
      begin
         wp_q      <= '0;
         rp_q      <= '0;
         lvl_q     <= '0;
         rd_data_q <= DATA_RESET;
         bit_q     <= '0;
         sh_q      <= '0;
         tx_q      <= '0;
      end
      else
      begin
         if (push) wp_q <= wp_q + 6'h01;
         if (pop)  rp_q <= rp_q + 6'h01;
         lvl_q <= lvl_q + 7'(push) - 7'(pop);
         if (sel & rd_act)
            rd_data_q <= is_fifo(acc_addr)        ? mem[rp_q] :
                         (acc_addr == LEVEL_ADDR) ? {1'b0, lvl_q} : DATA_RESET;
         if (!spi_sel)
            bit_q <= '0;
         else if (sck_rise)
         begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= {sh_q[6:0], pins_s.addr[0]};
            if (bit_q == 3'h7)
               tx_q <= (lvl_q != 7'h00) ? mem[rp_q] : DATA_RESET;
         end
         else if (sck_fall && bit_q != 3'h0)
            tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // *****************************
   // outputs
   // *****************************
   assign drive_o.data_o    = spi_sel ? {7'h00, tx_q[7]} : rd_data_q;
   assign drive_o.data_oe_n = (sel & rd_act & ~hold) ? 8'h00 : 8'hff;
   assign drive_o.miso_o    = tx_q[7];
   assign drive_o.miso_oe_n = ~(spi_sel & ~hold);
   assign irq      = started & irq_req;
   assign ready    = started;
   assign style    = style_q;
   assign spi_mode = spi_q;
endmodule : hbap_core

//--- bench/hbap_core_properties.sv
// Purpose: port properties of hbap_core
// Assumes: host pins pass two sync flops
// Notes:   bound to every hbap_core
`timescale 1ns/1ps
module hbap_core_properties
   import hbap_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_CYC
) (
   input wire logic                  sys_clk,
   input wire logic                  reset,
   input wire logic                  hard_reset_pin,
   input wire logic                  irq_req,
   input wire logic                  irq,
   input wire logic                  ready,
   input wire logic                  spi_mode,
   input wire hbap_pkg::hbap_pins_t  pins_i,
   input wire hbap_pkg::hbap_drive_t drive_o,
   input wire hbap_pkg::hbap_style_t style
);
   logic [CNT_W-1:0] wait_q;
   logic             seen_q;
   always_ff @(posedge sys_clk)
   begin
      wait_q <= (reset || hard_reset_pin || ready) ? '0 : wait_q + 1'b1;
      seen_q <= (reset || hard_reset_pin || !ready) ? 1'b0 : seen_q | !pins_i.chip_select_n;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   AST_HARD_DETACH: assert property (hard_reset_pin [*4] |-> &drive_o.data_oe_n && drive_o.miso_oe_n && !ready)
      else $error("bus held in hard reset");
   AST_START_BOUND: assert property (int'(wait_q) <= STARTUP_CYCLES + 8)
      else $error("start-up too long");
   AST_IRQ_PASS: assert property ((ready && irq_req) [*3] |-> irq)
      else $error("irq not passed");
   AST_IRQ_GATED: assert property (irq |-> ready && irq_req)
      else $error("irq without request");
   AST_UNSEL_QUIET: assert property (pins_i.chip_select_n [*4] |-> &drive_o.data_oe_n)
      else $error("bus driven unselected");
   AST_STROBE_QUIET: assert property (pins_i.read_strobe_n [*4] |-> &drive_o.data_oe_n)
      else $error("bus driven without strobe");
   AST_MISO_QUIET: assert property (pins_i.ale [*4] |-> drive_o.miso_oe_n)
      else $error("miso driven unselected");
   AST_MISO_SPI: assert property (!drive_o.miso_oe_n |-> spi_mode && !$past(pins_i.ale, 2))
      else $error("miso outside spi");
   AST_STYLE_KEPT: assert property (seen_q && $past(seen_q, 6) |-> $stable(style) && $stable(spi_mode))
      else $error("style changed");
endmodule : hbap_core_properties
bind hbap_core hbap_core_properties #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (.sys_clk(sys_clk), .reset(reset),
   .hard_reset_pin(hard_reset_pin), .irq_req(irq_req), .irq(irq), .ready(ready), .spi_mode(spi_mode),
   .pins_i(pins_i), .drive_o(drive_o), .style(style));

//--- bench/hbap_host_model.sv
// Purpose: host model, parallel and spi master
// Assumes: separate buses, rd/wr strobes
// Notes:   pins change 1 ns after a clock edge
`timescale 1ns/1ps
module hbap_host_model
   import hbap_pkg::*;
(
   input  wire logic [7:0]      bus_in,
   input  wire logic            sys_clk,
   output hbap_pkg::hbap_pins_t pins,
   output logic                 rd_valid,
   output logic [7:0]           rd_data
);
   initial
   begin
      pins = '1;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1 rd_valid = 1'b0;
   endtask : cyc
   task automatic par(input logic wr, input logic [2:0] a, input logic [7:0] d, input logic sel_n);
      pins.addr = a;
      pins.data = wr ? d : ~d;
      pins.chip_select_n = sel_n;
      cyc(1);
      pins.write_strobe_n = !wr;
      pins.read_strobe_n = wr;
      cyc(6);
      rd_data = bus_in;
      rd_valid = !wr;
      pins.write_strobe_n = 1'b1;
      pins.read_strobe_n = 1'b1;
      cyc(1);
      pins.chip_select_n = 1'b1;
      cyc(5);
   endtask : par
   task automatic spi(input logic [7:0] tx, input logic chk);
      if (pins.ale)
      begin
         pins.ale = 1'b0;
         pins.addr = 3'h0;
         cyc(8);
      end
      for (int i = 7; i >= 0; i--)
      begin
         pins.addr[0] = tx[i];
         cyc(4);
         rd_data[i] = bus_in[0];
         pins.addr[2] = 1'b1;
         cyc(4);
         pins.addr[2] = 1'b0;
      end
      rd_valid = chk;
      cyc(1);
   endtask : spi
endmodule : hbap_host_model

//--- bench/host_bus_autodetect_port_tb_top.sv
// Purpose: self-checking bench of hbap_core
// Assumes: start-up count cut to 20
// Notes:   reads queued by driver, popped by monitor
`timescale 1ns/1ps
module host_bus_autodetect_port_tb_top;
   import hbap_pkg::*;
   logic        sys_clk, reset, hard_reset_pin, irq_req, irq, ready, spi_mode, rd_valid;
   logic [7:0]  rd_data, b0, exp_q[$], fifo_q[$];
   hbap_pins_t  hp, pins_i;
   hbap_drive_t drive_o;
   hbap_style_t style;
   int          num_errors = 0, checks_done = 0, cyc_cnt = 0, n;
   always_comb
   begin
      pins_i = hp;
      pins_i.data = (hp.data & drive_o.data_oe_n) | (drive_o.data_o & ~drive_o.data_oe_n);
      if (!drive_o.miso_oe_n)
         pins_i.data[0] = drive_o.miso_o;
   end
   hbap_core #(.STARTUP_CYCLES(20)) dut (.sys_clk(sys_clk), .reset(reset), .hard_reset_pin(hard_reset_pin),
      .pins_i(pins_i), .irq_req(irq_req), .drive_o(drive_o), .irq(irq), .ready(ready), .style(style),
      .spi_mode(spi_mode));
   hbap_host_model host (.sys_clk(sys_clk), .bus_in(pins_i.data), .pins(hp), .rd_valid(rd_valid), .rd_data(rd_data));
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   task automatic wait_ready;
      for (int i = 0; i < 60 && ready !== 1'b1; i++)
         host.cyc(1);
      chk(8'h01, {7'h00, ready});
   endtask : wait_ready
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      if (rd_valid)
         chk(exp_q.pop_front(), rd_data);
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         num_errors++;
         results();
      end
   end
   initial
   begin
      reset = 1'b1;
      hard_reset_pin = 1'b0;
      irq_req = 1'b0;
      void'($urandom(64408));
      repeat (8) @(posedge sys_clk);
      #1 reset = 1'b0;
      wait_ready();
      host.par(1'b1, FIFO_ADDR, 8'h5a, 1'b1);
      n = 2 + int'($urandom_range(5));
      for (int i = 0; i < n; i++)
      begin
         fifo_q.push_back(8'($urandom));
         host.par(1'b1, FIFO_ADDR, fifo_q[i], 1'b0);
      end
      chk({6'h00, HB_SEP_RDWR}, {6'h00, style});
      exp_q.push_back(8'(n));
      host.par(1'b0, LEVEL_ADDR, 8'h00, 1'b0);
      exp_q.push_back(8'h00);
      host.par(1'b0, 3'h0, 8'h00, 1'b0);
      while (fifo_q.size() > 0)
      begin
         exp_q.push_back(fifo_q.pop_front());
         host.par(1'b0, FIFO_ADDR, 8'h00, 1'b0);
      end
      for (int i = 0; i < 4; i++)
      begin
         irq_req = n[0] ^ i[0];
         host.cyc(2);
         chk({7'h00, irq_req}, {7'h00, irq});
      end
      irq_req = 1'b0;
      hard_reset_pin = 1'b1;
      host.cyc(5);
      chk(8'h00, {6'h00, ready, irq});
      hard_reset_pin = 1'b0;
      wait_ready();
      b0 = 8'($urandom);
      host.spi(b0, 1'b0);
      exp_q.push_back(DATA_RESET);
      host.spi(8'h3c, 1'b1);
      exp_q.push_back(b0);
      host.spi(8'($urandom), 1'b1);
      chk(8'h01, {7'h00, spi_mode});
      host.cyc(4);
      chk(8'h00, 8'(exp_q.size()));
      results();
   end
endmodule : host_bus_autodetect_port_tb_top
